// File: rtl/flow_code_tx.sv
`timescale 1ns/1ns
module flow_code_tx
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Timing and setup
  input wire logic os_tick,
  input wire logic [1:0] parity_mode,
  // Character to send
  input wire logic start,
  input wire logic [7:0] code,
  // Line
  output logic txd,
  output logic busy
);

  // ---------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------
  // Start, eight data bits, optional parity and one stop bit.
  logic [10:0] frame;
  logic [3:0] bits_left;
  logic [3:0] tick_cnt;
  wire logic has_par = (parity_mode != prn_serial_pkg::PAR_NONE);
  wire logic par = prn_serial_pkg::parity_bit(code, parity_mode);
  wire logic [10:0] load_frame = has_par ? {1'b1, par, code, 1'b0}
                                         : {2'b11, code, 1'b0};
  wire logic [3:0] load_bits = has_par ? 4'hB : 4'hA;
  wire logic bit_end = os_tick && (tick_cnt == prn_serial_pkg::FULL_BIT);

  assign busy = (bits_left != 4'h0);
  assign txd = busy ? frame[0] : 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame <= 11'h7FF;
      bits_left <= 4'h0;
      tick_cnt <= 4'h0;
    end
    else if (!busy && start)
    begin
      frame <= load_frame;
      bits_left <= load_bits;
      tick_cnt <= 4'h0;
    end
    else if (busy && os_tick)
    begin
      tick_cnt <= tick_cnt + 4'h1;
      if (bit_end)
      begin
        frame <= {1'b1, frame[10:1]};
        bits_left <= bits_left - 4'h1;
      end
    end
  end

endmodule : flow_code_tx

// File: rtl/printer_serial_receiver_flow_ctrl.sv
`timescale 1ns/1ns
module printer_serial_receiver_flow_ctrl
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [prn_serial_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Serial line
  input wire logic rxd,
  output logic txd,
  output logic dtr,
  output logic rts2,
  // Input buffer side
  input wire logic [prn_serial_pkg::FREE_W-1:0] buffer_free,
  output logic char_valid,
  output logic [7:0] char_data,
  // Interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [6:0] ctrl;
  logic [prn_serial_pkg::EV_W-1:0] status;
  logic [prn_serial_pkg::EV_W-1:0] mask;
  logic [prn_serial_pkg::EV_W-1:0] events;
  logic [7:0] last_char;

  wire logic serial_on = ctrl[prn_serial_pkg::CTRL_EN];
  wire logic [2:0] rate_raw = ctrl[prn_serial_pkg::CTRL_RATE_LO +: 3];
  wire logic [1:0] parity_mode = ctrl[prn_serial_pkg::CTRL_PAR_LO +: 2];
  wire logic xon_mode = ctrl[prn_serial_pkg::CTRL_XON];
  wire logic [2:0] rate_sel = (rate_raw > prn_serial_pkg::RATE_19200)
                              ? prn_serial_pkg::RATE_19200 : rate_raw;

  wire logic sel_ctrl = (reg_addr == prn_serial_pkg::CTRL_ADDR);
  wire logic sel_status = (reg_addr == prn_serial_pkg::STATUS_ADDR);
  wire logic sel_mask = (reg_addr == prn_serial_pkg::MASK_ADDR);
  wire logic sel_flow = (reg_addr == prn_serial_pkg::FLOW_ADDR);
  wire logic sel_last = (reg_addr == prn_serial_pkg::LAST_ADDR);

  wire logic [prn_serial_pkg::EV_W-1:0] clear_bits =
    (reg_we && sel_status) ? reg_wdata[prn_serial_pkg::EV_W-1:0]
                           : {prn_serial_pkg::EV_W{1'b0}};
  // Set wins over clear so an event in the clearing cycle is kept.
  wire logic [prn_serial_pkg::EV_W-1:0] next_status =
    (status & ~clear_bits) | events;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= prn_serial_pkg::CTRL_RESET;
      mask <= {prn_serial_pkg::EV_W{1'b0}};
      status <= {prn_serial_pkg::EV_W{1'b0}};
    end
    else
    begin
      status <= next_status;
      if (reg_we && sel_ctrl)
      begin
        ctrl <= reg_wdata[6:0];
      end
      if (reg_we && sel_mask)
      begin
        mask <= reg_wdata[prn_serial_pkg::EV_W-1:0];
      end
    end
  end

  assign irq = |(status & mask);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic tx_busy;
  logic not_ready;
  wire logic [31:0] flow_word = {buffer_free, 13'h0000, tx_busy,
                                 xon_mode, not_ready};
  wire logic [31:0] read_mux =
    sel_ctrl ? {25'h0000000, ctrl} :
    sel_status ? {28'h0000000, status} :
    sel_mask ? {28'h0000000, mask} :
    sel_flow ? flow_word :
    sel_last ? {24'h000000, last_char} : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= reg_re ? read_mux : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Bit rate divider
  // ---------------------------------------------------------------
  // A fixed prescaler feeds a power-of-two divider, which keeps every
  // count short; the price is a rate error of about 0.2 percent.
  logic [8:0] base_cnt;
  logic [5:0] rate_cnt;
  wire logic base_tick = (base_cnt == prn_serial_pkg::BASE_LAST);
  wire logic [5:0] rate_last = 6'((7'h01 << (3'h6 - rate_sel)) - 7'h01);
  wire logic os_tick = base_tick && (rate_cnt >= rate_last);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_cnt <= 9'h000;
      rate_cnt <= 6'h00;
    end
    else
    begin
      base_cnt <= base_tick ? 9'h000 : base_cnt + 9'h001;
      if (base_tick)
      begin
        rate_cnt <= (rate_cnt >= rate_last) ? 6'h00 : rate_cnt + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive line synchroniser
  // ---------------------------------------------------------------
  logic rx_meta;
  logic rx_line;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
    end
    else
    begin
      rx_meta <= rxd;
      rx_line <= rx_meta;
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP = 3'h6
  } rx_state_e;

  rx_state_e rx_state;
  logic [3:0] rx_tick;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_par;

  wire logic rx_mid = os_tick && (rx_tick == prn_serial_pkg::HALF_BIT);
  wire logic rx_end = os_tick && (rx_tick == prn_serial_pkg::FULL_BIT);
  wire logic has_par = (parity_mode != prn_serial_pkg::PAR_NONE);
  wire logic par_fail = has_par &&
    (rx_par != prn_serial_pkg::parity_bit(rx_shift, parity_mode));
  // Gated so a frame that ends in the cycle the port is switched off is
  // not delivered after the interface has been deselected.
  wire logic rx_done = serial_on && (rx_state == RX_STOP) && rx_end;
  wire logic [7:0] rx_char = par_fail ? prn_serial_pkg::BAD_CHAR
                                      : rx_shift;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
    end
    else if (!serial_on)
    begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
    end
    else
    begin
      if (os_tick)
      begin
        rx_tick <= rx_tick + 4'h1;
      end
      unique case (rx_state)
        RX_IDLE:
        begin
          rx_tick <= 4'h0;
          if (!rx_line)
          begin
            rx_state <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_mid)
          begin
            rx_tick <= 4'h0;
            rx_bit <= 3'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_end)
          begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7)
            begin
              rx_state <= has_par ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY:
        begin
          if (rx_end)
          begin
            rx_par <= rx_line;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          // The stop level is not checked and a full buffer is not
          // reported; extra stop bits simply look like idle line.
          if (rx_end)
          begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      char_valid <= 1'b0;
      char_data <= 8'h00;
      last_char <= 8'h00;
    end
    else
    begin
      char_valid <= rx_done;
      if (rx_done)
      begin
        char_data <= rx_char;
        last_char <= rx_char;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flow control
  // ---------------------------------------------------------------
  // The host is trusted to pause on not-ready; characters that still
  // arrive are passed on regardless.
  logic send_off;
  logic send_on;
  wire logic at_low = (buffer_free <= prn_serial_pkg::LOW_MARK);
  wire logic at_high = (buffer_free >= prn_serial_pkg::HIGH_MARK);
  wire logic go_busy = !not_ready && at_low;
  wire logic go_ready = not_ready && at_high;
  wire logic tx_start = serial_on && xon_mode && (send_off || send_on);
  wire logic [7:0] tx_code = send_off ? prn_serial_pkg::XOFF_CODE
                                      : prn_serial_pkg::XON_CODE;
  logic tx_line;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      not_ready <= 1'b0;
      send_off <= 1'b0;
      send_on <= 1'b0;
    end
    else
    begin
      if (go_busy)
      begin
        not_ready <= 1'b1;
      end
      else if (go_ready)
      begin
        not_ready <= 1'b0;
      end
      if (go_busy)
      begin
        send_off <= xon_mode;
        send_on <= 1'b0;
      end
      else if (go_ready)
      begin
        send_on <= xon_mode;
        send_off <= 1'b0;
      end
      else if (tx_start && !tx_busy)
      begin
        send_off <= 1'b0;
        send_on <= 1'b0;
      end
    end
  end

  flow_code_tx u_tx
  (
    .clk(clk),
    .rst_n(rst_n),
    .os_tick(os_tick),
    .parity_mode(parity_mode),
    .start(tx_start),
    .code(tx_code),
    .txd(tx_line),
    .busy(tx_busy)
  );

  // MARK is logic one, so the line idles high and not-ready is high.
  assign txd = serial_on ? tx_line : 1'b1;
  assign dtr = not_ready || !serial_on;
  assign rts2 = dtr;

  assign events = serial_on ?
    {go_ready, go_busy, rx_done && par_fail, rx_done}
    : {prn_serial_pkg::EV_W{1'b0}};

endmodule : printer_serial_receiver_flow_ctrl

// File: rtl/prn_serial_pkg.sv
package prn_serial_pkg;

  // ---------------------------------------------------------------
  // Clock and bit timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int MAX_BAUD = 19200;
  localparam int OVERSAMPLE = 16;
  localparam int BASE_DIV = CLK_HZ / (MAX_BAUD * OVERSAMPLE);
  localparam logic [8:0] BASE_LAST = 9'(BASE_DIV - 1);
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] FULL_BIT = 4'hF;

  // Rate selection: value n gives 300 * 2**n bits per second for n up to 6; value 7 gives 19200, the same as 6.
  localparam logic [2:0] RATE_300 = 3'h0;
  localparam logic [2:0] RATE_9600 = 3'h5;
  localparam logic [2:0] RATE_19200 = 3'h6;

  // ---------------------------------------------------------------
  // Flow control
  // ---------------------------------------------------------------
  localparam int FREE_W = 16;
  localparam logic [FREE_W-1:0] LOW_MARK = 16'h0100;
  localparam logic [FREE_W-1:0] HIGH_MARK = 16'h0200;
  localparam logic [7:0] XOFF_CODE = 8'h13;
  localparam logic [7:0] XON_CODE = 8'h11;
  localparam logic [7:0] BAD_CHAR = 8'h2A;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR = 8'h08;
  localparam logic [7:0] FLOW_ADDR = 8'h0C;
  localparam logic [7:0] LAST_ADDR = 8'h10;

  localparam int CTRL_EN = 0;
  localparam int CTRL_RATE_LO = 1;
  localparam int CTRL_PAR_LO = 4;
  localparam int CTRL_XON = 6;
  localparam logic [6:0] CTRL_RESET = 7'h0B;

  localparam int EV_CHAR = 0;
  localparam int EV_PERR = 1;
  localparam int EV_BUSY = 2;
  localparam int EV_READY = 3;
  localparam int EV_W = 4;

  typedef enum logic [1:0]
  {
    PAR_NONE = 2'h0,
    PAR_ODD = 2'h1,
    PAR_EVEN = 2'h2
  } parity_e;

  // Expected parity bit for a byte under the given mode.
  function automatic logic parity_bit(input logic [7:0] d,
                                      input logic [1:0] mode);
    parity_bit = (mode == PAR_ODD) ? ~(^d) : (^d);
  endfunction : parity_bit

endpackage : prn_serial_pkg

// File: sim/host_uart_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host serial port, even parity, one stop bit
// ---------------------------------------------------------------
module host_uart_model
#(
  parameter int BIT_CLKS = 5200
)
(
  // Clock
  input wire logic clk,
  // Line
  output logic rxd,
  input wire logic txd,
  input wire logic dtr
);
  initial rxd = 1'b1;

  // The host holds off for up to 20000 clocks while the printer is not ready.
  task automatic send_byte(input logic [7:0] d, input logic bad,
                           output logic ok);
    logic [10:0] frame;
    int n;
    for (n = 0; n < 20000 && dtr !== 1'b0; n++)
      @(posedge clk);
    ok = dtr === 1'b0;
    frame = {1'b1, (^d) ^ bad, d, 1'b0};
    for (n = 0; n < 11; n++)
    begin
      rxd <= frame[n];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask : send_byte

  // Samples each bit in its middle; the line idles at mark.
  task automatic recv_byte(output logic [8:0] got, output logic ok);
    int n;
    got = 9'h000;
    for (n = 0; n < 2000 && txd !== 1'b0; n++)
      @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    ok = txd === 1'b0;
    for (n = 0; n < 9; n++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      got[n] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    ok = ok && txd === 1'b1;
  endtask : recv_byte
endmodule : host_uart_model

// File: sim/prn_serial_asserts.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module prn_serial_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [prn_serial_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  // Line and buffer
  input wire logic txd,
  input wire logic dtr,
  input wire logic rts2,
  input wire logic [prn_serial_pkg::FREE_W-1:0] buffer_free,
  input wire logic char_valid
);
  logic en_q;
  logic xon_q;
  wire ctrl_wr = reg_we && reg_addr == prn_serial_pkg::CTRL_ADDR;
  wire low = buffer_free <= prn_serial_pkg::LOW_MARK;
  wire high = buffer_free >= prn_serial_pkg::HIGH_MARK;

  // Shadow of the enable and code-mode bits, so the flow rules can be
  // judged without reading the control register back.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 1'b1;
      xon_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      en_q <= reg_wdata[prn_serial_pkg::CTRL_EN];
      xon_q <= reg_wdata[prn_serial_pkg::CTRL_XON];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence start_held;
    !txd [*8];
  endsequence
  sequence off_twice;
    !en_q ##1 !en_q;
  endsequence

  a_rts_same_dtr: assert property (rts2 == dtr)
    else $error("rts2 differs from dtr");
  a_busy_low_free: assert property (low |=> dtr)
    else $error("dtr not raised at low free space");
  a_ready_high_free: assert property (high && en_q && !ctrl_wr |=> !dtr)
    else $error("dtr not dropped at high free space");
  a_hold_between: assert property (!low && !high && !ctrl_wr |=> $stable(dtr))
    else $error("dtr moved between thresholds");
  a_off_not_ready: assert property (!en_q |-> dtr)
    else $error("dtr ready while port is off");
  a_off_no_char: assert property (off_twice |-> !char_valid)
    else $error("character delivered while port is off");
  a_no_code_sent: assert property (en_q && !xon_q |-> txd)
    else $error("code sent outside code mode");
  a_start_space: assert property ($fell(txd) |=> start_held)
    else $error("start bit too short");
  a_char_pulse: assert property (char_valid |=> !char_valid)
    else $error("character strobe longer than one cycle");
endmodule : prn_serial_asserts

bind printer_serial_receiver_flow_ctrl prn_serial_asserts u_asserts
(
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .txd, .dtr, .rts2,
  .buffer_free, .char_valid
);

// File: sim/tb_printer_serial_receiver_flow_ctrl.sv
`timescale 1ns/1ns
module tb_printer_serial_receiver_flow_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [prn_serial_pkg::ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic rxd;
  logic txd;
  logic dtr;
  logic rts2;
  logic [prn_serial_pkg::FREE_W-1:0] buffer_free = 16'h03E8;
  logic char_valid;
  logic [7:0] char_data;
  logic irq;
  int fails = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  printer_serial_receiver_flow_ctrl dut
  (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .rxd, .txd, .dtr, .rts2, .buffer_free, .char_valid, .char_data, .irq
  );
  host_uart_model host (.clk, .rxd, .txd, .dtr);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic set_free(input logic [15:0] v, input logic exp);
    buffer_free <= v;
    repeat (3) @(posedge clk);
    #1 check(dtr, exp, "dtr level");
    check(rts2, exp, "second rts");
    @(posedge clk);
  endtask : set_free

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    logic [31:0] v;
    rd(prn_serial_pkg::CTRL_ADDR, v);
    check(v, 32'h0000000B, "ctrl reset");
    rd(prn_serial_pkg::MASK_ADDR, v);
    check(v, 32'h00000000, "mask reset");
    rd(8'h20, v);
    check(v, 32'h00000000, "unmapped read");
    check({txd, dtr}, 32'h00000002, "idle line");
    $display("test reset done");
  endtask : test_reset

  task automatic test_hysteresis;
    wr(prn_serial_pkg::MASK_ADDR, 32'h0000000C);
    set_free(16'h0101, 1'b0);
    set_free(16'h0100, 1'b1);
    check(irq, 1'b1, "irq on busy");
    wr(prn_serial_pkg::STATUS_ADDR, 32'h0000000C);
    #1 check(irq, 1'b0, "irq cleared");
    @(posedge clk);
    set_free(16'h01FF, 1'b1);
    set_free(16'h0200, 1'b0);
    check({irq, txd}, 32'h00000003, "irq on ready, no code");
    wr(prn_serial_pkg::STATUS_ADDR, 32'h0000000F);
    $display("test hysteresis done");
  endtask : test_hysteresis

  task automatic test_disable;
    wr(prn_serial_pkg::CTRL_ADDR, 32'h0000000A);
    #1 check(dtr, 1'b1, "dtr while off");
    @(posedge clk);
    wr(prn_serial_pkg::CTRL_ADDR, 32'h0000006D);
    #1 check(dtr, 1'b0, "dtr back on");
    @(posedge clk);
    $display("test disable done");
  endtask : test_disable

  // A bad-parity byte arrives while the printer answers with a stop code.
  task automatic test_xoff_parity;
    logic ok1;
    logic ok2;
    logic [8:0] got;
    logic [31:0] v;
    int n;
    fork
      host.send_byte(8'h41, 1'b1, ok1);
      begin
        repeat (20) @(posedge clk);
        buffer_free <= 16'h00C8;
        host.recv_byte(got, ok2);
      end
      begin
        for (n = 0; n < 70000 && char_valid !== 1'b1; n++)
          @(posedge clk) #1;
        check(char_valid, 1'b1, "char strobe");
        check(char_data, 8'h2A, "substitute char");
        if (char_valid !== 1'b1)
          give_verdict;
      end
    join
    check(got, {^8'h13, 8'h13}, "stop code");
    check({ok1, ok2}, 32'h00000003, "frames");
    if (ok1 !== 1'b1 || ok2 !== 1'b1)
      give_verdict;
    rd(prn_serial_pkg::LAST_ADDR, v);
    check(v, 32'h0000002A, "last char");
    rd(prn_serial_pkg::STATUS_ADDR, v);
    check(v, 32'h00000007, "char, parity, busy events");
    $display("test stop code done");
  endtask : test_xoff_parity

  task automatic test_xon;
    int n;
    set_free(16'h012C, 1'b1);
    for (n = 0; n < 2000 && txd === 1'b1; n++)
      @(posedge clk);
    check(txd, 1'b1, "no second code");
    set_free(16'h0258, 1'b0);
    for (n = 0; n < 2000 && txd === 1'b1; n++)
      @(posedge clk);
    check(txd, 1'b0, "resume code starts");
    // Two data bits are enough to tell the resume code from the stop code.
    repeat (host.BIT_CLKS * 3 / 2) @(posedge clk);
    check(txd, 1'b1, "resume code bit 0");
    repeat (host.BIT_CLKS) @(posedge clk);
    check(txd, 1'b0, "resume code bit 1");
    $display("test resume done");
  endtask : test_xon

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset;
    test_hysteresis;
    test_disable;
    test_xoff_parity;
    test_xon;
    give_verdict;
  end
endmodule : tb_printer_serial_receiver_flow_ctrl
